//--- flr_chk_assertions.sv
// Port checker for the fault limit and response block.
// Bound onto every instance; sees only the block's top-level ports.
`default_nettype none
module flr_chk (
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        CMD_WR,
  input wire logic        CMD_RD,
  input wire logic [7:0]  CMD_CODE,
  input wire logic [15:0] CMD_WDATA,
  input wire logic        CLEAR_FAULTS,
  input wire logic        CLEAR_OT_BIT,
  input wire logic        OT_FAULT_PIN,
  input wire logic [15:0] CMD_RDATA,
  input wire logic        CMD_RVALID,
  input wire logic        OUTPUT_EN,
  input wire logic        OT_FAULT_LATCHED,
  input wire logic [15:0] OC_LV_LIMIT,
  input wire logic [15:0] OC_WARN_LIMIT,
  input wire logic [15:0] OT_LIMIT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] act_q; // Shadow of the response byte
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // ==========================================================
  // Shadow copy, so rules can key on the programmed action
  always_ff @(posedge SYS_CLK)
    if (RST) act_q <= 8'h00;
    else if (CMD_WR && CMD_CODE == 8'h50) act_q <= CMD_WDATA[7:0];
  a_lv_word_kept: assert property (
    CMD_WR && CMD_CODE == 8'h48 |=> OC_LV_LIMIT == $past(CMD_WDATA))
    else $error("low-volt limit not stored");
  a_warn_word_kept: assert property (
    CMD_WR && CMD_CODE == 8'h4a |=> OC_WARN_LIMIT == $past(CMD_WDATA))
    else $error("warning limit not stored");
  a_ot_read_back: assert property (
    CMD_RD && CMD_CODE == 8'h4f |=> CMD_RVALID && CMD_RDATA == $past(OT_LIMIT))
    else $error("limit read wrong");
  a_ignore_no_status: assert property (
    act_q[7:6] == 2'h0 && !CMD_WR && !OT_FAULT_LATCHED |=> !OT_FAULT_LATCHED)
    else $error("ignored fault set status");
  a_disable_fast: assert property (
    (act_q[7:6] == 2'h2 && OT_FAULT_PIN)[*4] |-> ##[0:2] !OUTPUT_EN)
    else $error("output not disabled");
  a_latch_stays_off: assert property (
    (OT_FAULT_LATCHED && act_q[7:6] == 2'h3)[*2] |-> !OUTPUT_EN)
    else $error("latched fault left output on");
  a_no_retry_off: assert property (
    (OT_FAULT_LATCHED && act_q[7:3] == 5'h10)[*2] |-> !OUTPUT_EN)
    else $error("restart without retries");
  a_clear_drops: assert property ((!OT_FAULT_PIN)[*3] ##0 (CLEAR_FAULTS || CLEAR_OT_BIT)
    |-> ##[1:2] !OT_FAULT_LATCHED)
    else $error("clear ignored");
endmodule // flr_chk
bind flr_fault_limit_and_response flr_chk flr_chk_i (.*);
`default_nettype wire

//--- flr_consts.vh
// Constants for the fault limit and response block: command codes, field
// positions, action and retry codes, and reset values. Definitions only.
`ifndef FLR_CONSTS_VH
`define FLR_CONSTS_VH
// ==========================================================================
// Command codes
`define FLR_CMD_OC_LV_LIMIT   8'h48
`define FLR_CMD_OC_WARN_LIMIT 8'h4a
`define FLR_CMD_OT_LIMIT      8'h4f
`define FLR_CMD_OT_ACTION     8'h50
`define FLR_CMD_DELAY_UNIT    8'hd2
// ==========================================================================
// Response byte fields
`define FLR_ACT_HI   7
`define FLR_ACT_LO   6
`define FLR_RTY_HI   5
`define FLR_RTY_LO   3
`define FLR_DLY_HI   2
`define FLR_DLY_LO   0
// Response actions
`define FLR_ACT_IGNORE  2'h0
`define FLR_ACT_DELAY   2'h1
`define FLR_ACT_RETRY   2'h2
`define FLR_ACT_LATCH   2'h3
// Retry settings
`define FLR_RTY_NONE    3'h0
`define FLR_RTY_FOREVER 3'h7
// ==========================================================================
// Reset values
`define FLR_RST_WORD    16'h0000
`define FLR_RST_ACTION  8'h00
`define FLR_RST_UNIT    16'h0001
`endif

//--- flr_fault_limit_and_response.v
// Fault limit registers and over-temperature response sequencer.
// Assumes a PMBus command decoder on SYS_CLK giving one-cycle write strobes
// and a combinational-free read path; the fault and control inputs are pins.
`default_nettype none
`include "flr_consts.vh"

// Functional notes
// - Read/write over-current low-voltage fault limit word
// - Read/write over-current warning limit word
// - Read/write over-temperature fault limit word
// - Response byte: action, retries, delay fields
// - Action 00: ignore fault, keep running
// - Action 01: run for delay, then retry
// - Action 10: disable immediately, then retry
// - Action 11: stay off until fault cleared
// - Retry 000: no restart, stay off
// - Retry 1..6: that many restarts, then latch
// - Restart starts spaced by delay time
// - Retry 111: retry forever until commanded off
// - Delay field decodes to 2^n units
// - Delay unit length from separate register
module flr_fault_limit_and_response (
  input  wire        SYS_CLK,       // 100 MHz system clock
  input  wire        RST,           // Synchronous active-high reset
  input  wire        CMD_WR,        // One-cycle write strobe
  input  wire        CMD_RD,        // One-cycle read strobe
  input  wire [7:0]  CMD_CODE,      // Command code
  input  wire [15:0] CMD_WDATA,     // Write data, bytes in low bits
  input  wire        CLEAR_FAULTS,  // Clear-all command pulse
  input  wire        CLEAR_OT_BIT,  // Individual over-temperature clear pulse
  input  wire        OT_FAULT_PIN,  // Over-temperature comparator, async
  input  wire        OUTPUT_ON_PIN, // Combined on/off command level, async
  input  wire        OTHER_SHUTDOWN,// Another fault forcing shutdown, async
  output reg  [15:0] CMD_RDATA,     // Read data
  output reg         CMD_RVALID,    // Read data valid pulse
  output reg         OUTPUT_EN,     // Output enable to the power stage
  output reg         OT_FAULT_LATCHED, // Over-temperature status bit
  output reg  [15:0] OC_LV_LIMIT,   // Limit words to the comparators
  output reg  [15:0] OC_WARN_LIMIT,
  output reg  [15:0] OT_LIMIT
);

  // ========================================================================
  // States
  localparam [2:0] ST_RUN   = 3'h0; // Normal operation
  localparam [2:0] ST_GRACE = 3'h1; // Running on through the delay
  localparam [2:0] ST_WAIT  = 3'h2; // Off, waiting before a restart
  localparam [2:0] ST_TRY   = 3'h3; // Restart attempt in progress
  localparam [2:0] ST_LATCH = 3'h4; // Off until cleared

  // ========================================================================
  // Registers
  reg [7:0]  ot_action_q;           // Response byte
  reg [15:0] delay_unit_q;          // Cycles per delay time unit
  reg [2:0]  state_q;               // Sequencer state
  reg [2:0]  tries_q;               // Restarts already made
  reg [7:0]  units_q;               // Delay units elapsed
  reg [15:0] tick_q;                // Cycles within a unit
  reg        ot_s1_q, on_s1_q, sd_s1_q; // Synchroniser stages
  reg        ot_q, on_q, sd_q;      // Synchronised inputs
  reg        on_prev_q;             // For off-then-on detection

  wire [1:0] act = ot_action_q[`FLR_ACT_HI:`FLR_ACT_LO];
  wire [2:0] rty = ot_action_q[`FLR_RTY_HI:`FLR_RTY_LO];
  wire [2:0] dly = ot_action_q[`FLR_DLY_HI:`FLR_DLY_LO];

  // Delay field to unit count, 1..128
  function [7:0] units_of;
    input [2:0] f;
    begin
      units_of = 8'h01 << f;
    end
  endfunction

  // Retry budget left: 111 never runs out
  function more_tries;
    input [2:0] setting;
    input [2:0] done;
    begin
      more_tries = (setting == `FLR_RTY_FOREVER) || (done < setting);
    end
  endfunction

  wire unit_end  = (tick_q + 16'h0001 >= delay_unit_q);
  wire delay_end = unit_end && (units_q + 8'h01 >= units_of(dly));
  // Off-then-on edge on the combined control level
  wire on_rise   = on_q && !on_prev_q;
  wire clear_ev  = CLEAR_FAULTS || CLEAR_OT_BIT || on_rise;

  // ========================================================================
  // Input synchronisers: first stage feeds only the second
  always @(posedge SYS_CLK) begin
    ot_s1_q   <= OT_FAULT_PIN;
    on_s1_q   <= OUTPUT_ON_PIN;
    sd_s1_q   <= OTHER_SHUTDOWN;
    ot_q      <= ot_s1_q;
    on_q      <= on_s1_q;
    sd_q      <= sd_s1_q;
    on_prev_q <= on_q;
  end

  // ========================================================================
  // Register writes and reads
  always @(posedge SYS_CLK) begin
    CMD_RVALID <= 1'b0;
    if (RST) begin
      OC_LV_LIMIT   <= `FLR_RST_WORD;
      OC_WARN_LIMIT <= `FLR_RST_WORD;
      OT_LIMIT      <= `FLR_RST_WORD;
      ot_action_q   <= `FLR_RST_ACTION;
      delay_unit_q  <= `FLR_RST_UNIT;
      CMD_RDATA     <= 16'h0000;
    end else begin
      if (CMD_WR) begin
        case (CMD_CODE)
          `FLR_CMD_OC_LV_LIMIT:   OC_LV_LIMIT   <= CMD_WDATA;
          `FLR_CMD_OC_WARN_LIMIT: OC_WARN_LIMIT <= CMD_WDATA;
          `FLR_CMD_OT_LIMIT:      OT_LIMIT      <= CMD_WDATA;
          `FLR_CMD_OT_ACTION:     ot_action_q   <= CMD_WDATA[7:0];
          // A zero unit would end a unit every cycle, just as one does; it is held at one
          `FLR_CMD_DELAY_UNIT: delay_unit_q <= (CMD_WDATA == 16'h0000) ?
                                              16'h0001 : CMD_WDATA;
          default: ;
        endcase
      end
      if (CMD_RD) begin
        CMD_RVALID <= 1'b1;
        case (CMD_CODE)
          `FLR_CMD_OC_LV_LIMIT:   CMD_RDATA <= OC_LV_LIMIT;
          `FLR_CMD_OC_WARN_LIMIT: CMD_RDATA <= OC_WARN_LIMIT;
          `FLR_CMD_OT_LIMIT:      CMD_RDATA <= OT_LIMIT;
          `FLR_CMD_OT_ACTION:     CMD_RDATA <= {8'h00, ot_action_q};
          `FLR_CMD_DELAY_UNIT:    CMD_RDATA <= delay_unit_q;
          default:                CMD_RDATA <= 16'h0000;
        endcase
      end
    end
  end

  // ========================================================================
  // Response sequencer
  always @(posedge SYS_CLK) begin
    if (RST) begin
      state_q          <= ST_RUN;
      tries_q          <= 3'h0;
      units_q          <= 8'h00;
      tick_q           <= 16'h0000;
      OUTPUT_EN        <= 1'b0;
      OT_FAULT_LATCHED <= 1'b0;
    end else begin
      // Timer runs by default; states restart it as needed
      if (unit_end) begin
        tick_q  <= 16'h0000;
        units_q <= units_q + 8'h01;
      end else begin
        tick_q  <= tick_q + 16'h0001;
      end
      // Status: a new fault wins over a clear in the same cycle
      if (ot_q && act != `FLR_ACT_IGNORE)
        OT_FAULT_LATCHED <= 1'b1;
      else if (clear_ev)
        OT_FAULT_LATCHED <= 1'b0;
      if (clear_ev && !ot_q) begin
        // A clear with the fault input low restarts the sequence from scratch
        state_q <= ST_RUN;
        tries_q <= 3'h0;
        units_q <= 8'h00;
        tick_q  <= 16'h0000;
        OUTPUT_EN <= on_q;
      end else if (!on_q || sd_q) begin
        // Commanded off or other shutdown ends retrying
        state_q   <= ST_LATCH;
        OUTPUT_EN <= 1'b0;
      end else begin
        case (state_q)
          ST_RUN: begin
            OUTPUT_EN <= 1'b1;
            units_q   <= 8'h00;
            tick_q    <= 16'h0000;
            if (ot_q) begin
              case (act)
                `FLR_ACT_IGNORE: OUTPUT_EN <= 1'b1;
                `FLR_ACT_DELAY:  state_q   <= ST_GRACE;
                `FLR_ACT_RETRY: begin
                  OUTPUT_EN <= 1'b0;
                  state_q   <= more_tries(rty, 3'h0) ? ST_WAIT : ST_LATCH;
                end
                default: begin
                  OUTPUT_EN <= 1'b0;
                  state_q   <= ST_LATCH;
                end
              endcase
            end
          end
          ST_GRACE: begin
            if (!ot_q) begin
              state_q <= ST_RUN;
            end else if (delay_end) begin
              // Fault outlived the delay: fall into the retry setting
              OUTPUT_EN <= 1'b0;
              units_q   <= 8'h00;
              tick_q    <= 16'h0000;
              state_q   <= more_tries(rty, tries_q) ? ST_WAIT : ST_LATCH;
            end
          end
          ST_WAIT: begin
            OUTPUT_EN <= 1'b0;
            if (delay_end) begin
              OUTPUT_EN <= 1'b1;
              units_q   <= 8'h00;
              tick_q    <= 16'h0000;
              if (tries_q != `FLR_RTY_FOREVER)
                tries_q <= tries_q + 3'h1;
              state_q <= ST_TRY;
            end
          end
          ST_TRY: begin
            // Attempt ends on a fault or after one fault-free delay; the wait spaces starts one delay apart
            if (ot_q) begin
              OUTPUT_EN <= 1'b0;
              state_q   <= more_tries(rty, tries_q) ? ST_WAIT : ST_LATCH;
            end else if (delay_end) begin
              state_q <= ST_RUN;
              tries_q <= 3'h0;
            end
          end
          ST_LATCH: OUTPUT_EN <= 1'b0;
          default: state_q <= ST_LATCH;
        endcase
      end
    end
  end

endmodule // flr_fault_limit_and_response
`default_nettype wire

//--- flr_host.sv
// Host model: one register write or read at a time.
// Assumes a read answers with a valid pulse one cycle later.
`default_nettype none
module flr_host (
  input  wire logic        clk,
  input  wire logic [15:0] rdata,
  input  wire logic        rvalid,
  output var  logic        wr = 1'b0,
  output var  logic        rd = 1'b0,
  output var  logic [7:0]  code = 8'h00,
  output var  logic [15:0] wdata = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  // Write: strobe stands for the one taking edge only
  task automatic put(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    code <= c;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d; // Released bus must not show stale data
  endtask
  // Read: data taken at the edge where valid is high
  task automatic get(input logic [7:0] c, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    code <= c;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = (rvalid === 1'b1) ? rdata : 16'hdead;
  endtask
endmodule // flr_host
`default_nettype wire

//--- tb_top.sv
// Testbench for the fault limit block, host model on the command port.
// Pins are driven here at the rising edge.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, clr_all = 1'b0, clr_ot = 1'b0;
  logic ot_pin = 1'b0, on_pin = 1'b0, sd = 1'b0;
  wire logic wr, rd, rv, en, lat;
  wire logic [7:0] code;
  wire logic [15:0] wd, rdat, l1, l2, l3;
  int err_total = 0, num_checks = 0;
  always #5 clk = ~clk;
  flr_host flr_host_i (.clk(clk), .rdata(rdat), .rvalid(rv), .wr(wr), .rd(rd),
    .code(code), .wdata(wd));
  flr_fault_limit_and_response flr_fault_limit_and_response_i (.SYS_CLK(clk),
    .RST(rst), .CMD_WR(wr), .CMD_RD(rd), .CMD_CODE(code), .CMD_WDATA(wd),
    .CLEAR_FAULTS(clr_all), .CLEAR_OT_BIT(clr_ot), .OT_FAULT_PIN(ot_pin),
    .OUTPUT_ON_PIN(on_pin), .OTHER_SHUTDOWN(sd), .CMD_RDATA(rdat), .CMD_RVALID(rv),
    .OUTPUT_EN(en), .OT_FAULT_LATCHED(lat), .OC_LV_LIMIT(l1), .OC_WARN_LIMIT(l2),
    .OT_LIMIT(l3));
  task automatic check(input string what, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Reset, then command the output on by a rising edge
  task automatic do_reset;
    rst <= 1'b1;
    ot_pin <= 1'b0;
    on_pin <= 1'b0;
    sd <= 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    on_pin <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  // Count output restarts and the closest spacing of their starts
  task automatic watch(input int cyc, output int r, output int g);
    int last;
    logic prev;
    r = 0;
    g = 9999;
    last = 0;
    prev = en;
    for (int i = 1; i <= cyc; i++) begin
      @(posedge clk);
      if (en && !prev) begin
        if (r > 0 && i - last < g) g = i - last;
        r++;
        last = i;
      end
      prev = en;
    end
  endtask
  task automatic s_regs;
    logic [15:0] d;
    logic [7:0] c[6] = '{8'h48, 8'h4a, 8'h4f, 8'h50, 8'h55, 8'hd2};
    logic [15:0] v[6] = '{16'ha5c3, 16'h5a3c, 16'hffff, 16'h12ff, 16'h7777, 16'h0000};
    logic [15:0] x[6] = '{16'ha5c3, 16'h5a3c, 16'hffff, 16'h00ff, 16'h0000, 16'h0001};
    flr_host_i.get(8'h4f, d);
    check("limit after reset", d, 16'h0000);
    foreach (c[i]) flr_host_i.put(c[i], v[i]);
    foreach (c[i]) begin
      flr_host_i.get(c[i], d);
      check("readback", d, x[i]);
    end
    check("low-volt pins", l1, 16'ha5c3);
    check("warning pins", l2, 16'h5a3c);
    check("ot limit pins", l3, 16'hffff);
  endtask
  // Action 00: fault present, output stays on and no status
  task automatic s_ignore;
    flr_host_i.put(8'h50, 16'h0000);
    ot_pin <= 1'b1;
    repeat (20) @(posedge clk);
    check("ignored fault", {14'h0, en, lat}, 16'h0002);
  endtask
  task automatic s_latch(input int m);
    do_reset;
    flr_host_i.put(8'h50, 16'h00c0);
    ot_pin <= 1'b1;
    repeat (8) @(posedge clk);
    ot_pin <= 1'b0;
    repeat (8) @(posedge clk);
    check("held off", {14'h0, en, lat}, 16'h0001);
    if (m == 0) clr_ot <= 1'b1;
    if (m == 1) clr_all <= 1'b1;
    if (m == 2) on_pin <= 1'b0;
    repeat (4) @(posedge clk);
    clr_ot <= 1'b0;
    clr_all <= 1'b0;
    on_pin <= 1'b1;
    repeat (8) @(posedge clk);
    check("after clear", {14'h0, en, lat}, 16'h0002);
  endtask
  task automatic s_retry(input logic [7:0] a, input logic [15:0] u, input int n, dc);
    int r, g;
    do_reset;
    flr_host_i.put(8'hd2, u);
    flr_host_i.put(8'h50, {8'h00, a});
    ot_pin <= 1'b1;
    watch(300, r, g);
    if (n < 7) check("restarts", 16'(r), 16'(n));
    else check("retries on", {15'h0, r > 6}, 16'h0001);
    if (n > 1) check("spacing", {15'h0, g >= dc && g <= dc + 4}, 16'h0001);
    sd <= 1'b1;
    repeat (6) @(posedge clk);
    watch(40, r, g);
    check("stays off", {15'h0, en}, 16'h0000);
    check("no restart", 16'(r), 16'h0000);
  endtask
  task automatic s_delay;
    do_reset;
    flr_host_i.put(8'hd2, 16'h0003);
    flr_host_i.put(8'h50, 16'h0042);
    ot_pin <= 1'b1;
    repeat (9) @(posedge clk);
    check("runs in delay", {15'h0, en}, 16'h0001);
    repeat (15) @(posedge clk);
    check("off after delay", {14'h0, en, lat}, 16'h0001);
  endtask
  initial begin
    do_reset;
    s_regs;
    s_ignore;
    for (int m = 0; m < 3; m++) s_latch(m);
    s_retry(8'h91, 16'h0004, 2, 8);
    s_retry(8'hb0, 16'h0004, 6, 4);
    s_retry(8'h80, 16'h0001, 0, 1);
    s_retry(8'hb8, 16'h0001, 7, 1);
    s_delay;
    report_and_stop;
  end
  // Watchdog: the whole run needs about a sixth of this span
  initial begin
    #100us;
    err_total++;
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
